// ==== pmw_cpu_model.sv ====
// Processor-side bus master model for the register slave
`timescale 1ns/1ns
`include "pmw_map.svh"
module pmw_cpu_model (
  // Bus
  input wire logic hclk,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [31:0] hwdata,
  // Wait bound ran out
  output logic hung
);
  // Idle bus at time zero
  initial begin
    {hsel, haddr, htrans, hwrite, hwdata, hung} = '0;
  end
  // Waits for ready at a rising edge, bounded
  task automatic wait_rdy();
    int i;
    for (i = 0; i < 50; i++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) break;
    end
    if (i == 50) hung = 1'b1;
  endtask
  // One single word transfer; upper option bits always go out as zero
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= (idx == `PMW_IDX_OPM) ? (wd & 32'h3) : wd;
    wait_rdy();
    rd = hrdata;
  endtask
endmodule

// ==== pmw_ctrl.sv ====
// Power mode, wakeup and reset cause controller with AHB-Lite register slave
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ns
`include "pmw_map.svh"

module pmw_ctrl #(
  parameter int RST_SEQ_CYC = `PMW_RST_SEQ_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,

  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,

  // Wakeup sources from pins and analog
  input wire logic wake_pin,
  input wire logic wake_comp,

  // Wakeup sources from on-chip logic
  input wire logic wake_tick,
  input wire logic radio_interrupt,
  input wire logic pin_wakeup_interrupt,
  input wire logic [7:0] interrupt_enable_reg_one,

  // Miscellaneous interrupt sources
  input wire logic crystal_oscillator_fast_ready,
  input wire logic adc_done,
  input wire logic rng_ready,

  // Reset sources
  input wire logic reset_pin_n,
  input wire logic wdt_reset_req,
  input wire logic dbg_reset_req,

  // Power and reset controls
  output logic [2:0] power_mode,
  output logic power_down,
  output logic cpu_clk_stop,
  output logic wakeup_timer_stop,
  output logic retention_latch_lock,
  output logic wdt_hold_reset,
  output logic sys_reset,
  output logic miscellaneous_interrupt
);

  // Reset image of the whole state
  localparam pmw_pkg::pmw_state_s ST_RST = '{
    fsm: pmw_pkg::PMW_ST_ACTIVE,
    cur_mode: 3'h0,
    prev_mode: 3'h0,
    wake_flags: 3'h0,
    opm: 2'h0,
    wus: `PMW_WUS_RST,
    cause: 3'h0,
    seq_cnt: 16'(RST_SEQ_CYC),
    rst_out: 1'b1,
    misc_irq: 1'b0,
    pin_s: 2'h0,
    comp_s: 2'h0,
    rstp_s: 2'h3,
    dp_wr: 1'b0,
    dp_rd: 1'b0,
    rd_done: 1'b0,
    dp_idx: 8'h00,
    rdata: 32'h0000_0000
  };

  pmw_pkg::pmw_state_s st_ff;
  pmw_pkg::pmw_state_s nxt_st;

  logic addr_ok;
  logic rst_evt;
  logic down;
  logic [2:0] wr_mode;
  logic mode_ok;
  logic sb_radio;
  logic sb_tick;
  logic sb_pin;
  logic sb_misc;
  logic w_pin;
  logic w_tick;
  logic w_comp;
  logic w_any;

  // Standby wake decision for one source from its select pair
  function automatic logic sb_wake(input logic [1:0] sel, input logic irq, input logic en);
    logic r;
    r = 1'b0;
    if (sel == `PMW_WSEL_IF_EN) begin
      r = irq & en;
    end else if (sel == `PMW_WSEL_ALWAYS) begin
      r = irq;
    end
    return r;
  endfunction

  // Bus outputs; reads take one wait state so data comes from a flop
  assign hreadyout = !(st_ff.dp_rd && !st_ff.rd_done);
  assign hresp = 1'b0;
  assign hrdata = st_ff.rdata;

  // Control outputs
  assign down = (st_ff.fsm == pmw_pkg::PMW_ST_DOWN);
  assign power_mode = st_ff.cur_mode;
  assign power_down = down && (st_ff.cur_mode != pmw_pkg::PMW_MODE_STANDBY);
  assign cpu_clk_stop = down && (st_ff.cur_mode == pmw_pkg::PMW_MODE_STANDBY); // [RQ3]
  assign retention_latch_lock = st_ff.opm[`PMW_OPM_LATCH_BIT]; // [RQ9]
  assign sys_reset = st_ff.rst_out;
  assign miscellaneous_interrupt = st_ff.misc_irq;

  // Wakeup timer halts in deep sleep and in retention with timer off
  always_comb begin
    wakeup_timer_stop = 1'b0;
    if (down) begin
      wakeup_timer_stop = (st_ff.cur_mode == pmw_pkg::PMW_MODE_DEEP) ||
                          (st_ff.cur_mode == pmw_pkg::PMW_MODE_MEM_TOFF); // [RQ2]
    end
  end

  // Watchdog held in reset in deep sleep, and in retention when enabled
  always_comb begin
    wdt_hold_reset = 1'b0;
    if (down) begin
      if (st_ff.cur_mode == pmw_pkg::PMW_MODE_DEEP) begin
        wdt_hold_reset = 1'b1; // [RQ11]
      end else if (st_ff.cur_mode == pmw_pkg::PMW_MODE_MEM_TOFF ||
                   st_ff.cur_mode == pmw_pkg::PMW_MODE_MEM_TON ||
                   st_ff.cur_mode == pmw_pkg::PMW_MODE_REG_RET) begin
        wdt_hold_reset = st_ff.opm[`PMW_OPM_WDT_BIT]; // [RQ11]
      end
    end
  end

  // Standby wake per source, gated by the select pairs
  always_comb begin
    sb_radio = sb_wake(st_ff.wus[`PMW_WUS_RADIO_LSB +: 2], radio_interrupt,
                       interrupt_enable_reg_one[1]); // [RQ18]
    sb_tick = sb_wake(st_ff.wus[`PMW_WUS_TICK_LSB +: 2], wake_tick,
                      interrupt_enable_reg_one[5]); // [RQ19]
    sb_pin = sb_wake(st_ff.wus[`PMW_WUS_PIN_LSB +: 2], pin_wakeup_interrupt,
                     interrupt_enable_reg_one[3]); // [RQ20]
    sb_misc = sb_wake(st_ff.wus[`PMW_WUS_MISC_LSB +: 2], st_ff.misc_irq,
                      interrupt_enable_reg_one[4]); // [RQ21]
  end

  // Wake causes for the mode in effect
  always_comb begin
    w_pin = 1'b0;
    w_tick = 1'b0;
    w_comp = 1'b0;
    w_any = 1'b0;
    unique case (st_ff.cur_mode)
      pmw_pkg::PMW_MODE_STANDBY: begin
        w_pin = sb_pin;
        w_tick = sb_tick;
        w_any = sb_radio | sb_tick | sb_pin | sb_misc; // [RQ17]
      end
      pmw_pkg::PMW_MODE_DEEP: begin
        w_pin = st_ff.pin_s[1];
        w_any = w_pin;
      end
      pmw_pkg::PMW_MODE_MEM_TOFF: begin
        w_pin = st_ff.pin_s[1];
        w_comp = st_ff.comp_s[1];
        w_any = w_pin | w_comp;
      end
      default: begin
        w_pin = st_ff.pin_s[1];
        w_tick = wake_tick;
        w_comp = st_ff.comp_s[1];
        w_any = w_pin | w_tick | w_comp;
      end
    endcase
  end

  // Decode of a written mode code
  always_comb begin
    wr_mode = hwdata[2:0];
    mode_ok = (wr_mode != pmw_pkg::PMW_MODE_NONE) && // [RQ1]
              (wr_mode != pmw_pkg::PMW_MODE_RSV5) && // [RQ23]
              (wr_mode != pmw_pkg::PMW_MODE_RSV6);   // [RQ23]
  end

  // Address phase qualifier and reset source detection
  assign addr_ok = hsel && htrans[1] && hready;
  assign rst_evt = !st_ff.rstp_s[1] || wdt_reset_req || dbg_reset_req;

  // Next state of the whole controller
  always_comb begin
    nxt_st = st_ff;

    // Input synchronisers
    nxt_st.pin_s = {st_ff.pin_s[0], wake_pin};
    nxt_st.comp_s = {st_ff.comp_s[0], wake_comp};
    nxt_st.rstp_s = {st_ff.rstp_s[0], reset_pin_n};

    // Miscellaneous interrupt request
    nxt_st.misc_irq = crystal_oscillator_fast_ready | adc_done | rng_ready; // [RQ22]

    // Data phase of a write
    nxt_st.dp_wr = 1'b0;
    if (st_ff.dp_wr) begin
      unique case (st_ff.dp_idx)
        `PMW_IDX_PDC: begin
          if (mode_ok && st_ff.fsm == pmw_pkg::PMW_ST_ACTIVE) begin
            nxt_st.fsm = pmw_pkg::PMW_ST_DOWN; // [RQ1]
            nxt_st.cur_mode = wr_mode; // [RQ2] [RQ3]
            nxt_st.wake_flags = 3'h0; // [RQ8]
          end
        end
        `PMW_IDX_WUS: begin
          nxt_st.wus = hwdata[7:0];
        end
        `PMW_IDX_OPM: begin
          nxt_st.opm = hwdata[1:0];
        end
        `PMW_IDX_RCA: begin
          nxt_st.cause = 3'h0; // [RQ15]
        end
        default: begin
        end
      endcase
    end

    // Data phase of a read: capture, then release the bus
    if (st_ff.dp_rd && !st_ff.rd_done) begin
      nxt_st.rd_done = 1'b1;
      nxt_st.rdata = 32'h0000_0000;
      unique case (st_ff.dp_idx)
        `PMW_IDX_PDC: begin
          nxt_st.rdata[7:5] = st_ff.wake_flags; // [RQ5] [RQ6] [RQ7]
          nxt_st.rdata[2:0] = st_ff.prev_mode; // [RQ4]
          nxt_st.wake_flags = 3'h0; // [RQ8]
        end
        `PMW_IDX_WUS: begin
          nxt_st.rdata[7:0] = st_ff.wus;
        end
        `PMW_IDX_OPM: begin
          nxt_st.rdata[1:0] = st_ff.opm;
        end
        `PMW_IDX_RCA: begin
          nxt_st.rdata[2:0] = st_ff.cause;
        end
        default: begin
        end
      endcase
    end else if (st_ff.dp_rd) begin
      nxt_st.dp_rd = 1'b0;
      nxt_st.rd_done = 1'b0;
    end

    // Address phase
    if (addr_ok) begin
      nxt_st.dp_idx = haddr[9:2];
      nxt_st.dp_wr = hwrite && (haddr[31:10] == 22'h0);
      nxt_st.dp_rd = !hwrite;
      nxt_st.rd_done = 1'b0;
      if (haddr[31:10] != 22'h0) begin
        nxt_st.dp_idx = 8'h00;
      end
    end

    // Power sequencer
    unique case (st_ff.fsm)
      pmw_pkg::PMW_ST_ACTIVE: begin
      end
      pmw_pkg::PMW_ST_DOWN: begin
        if (w_any) begin
          nxt_st.fsm = pmw_pkg::PMW_ST_WAKE;
          nxt_st.prev_mode = st_ff.cur_mode; // [RQ4]
          // Mode output drops with the wake so mode and stop controls agree
          nxt_st.cur_mode = pmw_pkg::PMW_MODE_NONE;
          // Set wins over a read clear in the same cycle
          nxt_st.wake_flags[`PMW_PDC_PIN_BIT - 5] = w_pin; // [RQ5]
          nxt_st.wake_flags[`PMW_PDC_TICK_BIT - 5] = w_tick; // [RQ6]
          nxt_st.wake_flags[`PMW_PDC_COMP_BIT - 5] = w_comp; // [RQ7]
        end
      end
      pmw_pkg::PMW_ST_WAKE: begin
        nxt_st.fsm = pmw_pkg::PMW_ST_ACTIVE;
        nxt_st.cur_mode = pmw_pkg::PMW_MODE_NONE;
      end
      default: begin
        nxt_st.fsm = pmw_pkg::PMW_ST_ACTIVE;
      end
    endcase

    // Reset sequence countdown
    if (st_ff.seq_cnt != 16'h0) begin
      nxt_st.seq_cnt = st_ff.seq_cnt - 16'h1;
    end

    // Reset sources restart the sequence and record causes
    if (rst_evt) begin
      nxt_st.seq_cnt = 16'(RST_SEQ_CYC); // [RQ13]
      nxt_st.fsm = pmw_pkg::PMW_ST_ACTIVE;
      nxt_st.cur_mode = pmw_pkg::PMW_MODE_NONE;
      nxt_st.wus = `PMW_WUS_RST;
      nxt_st.opm = 2'h0;
      nxt_st.dp_wr = 1'b0;
      // Causes OR in and win over a clearing write
      nxt_st.cause[`PMW_RCA_PIN_BIT] = st_ff.cause[`PMW_RCA_PIN_BIT] && !(st_ff.dp_wr &&
        st_ff.dp_idx == `PMW_IDX_RCA) || !st_ff.rstp_s[1]; // [RQ14] [RQ16]
      nxt_st.cause[`PMW_RCA_WDT_BIT] = nxt_st.cause[`PMW_RCA_WDT_BIT] | wdt_reset_req; // [RQ14] [RQ16]
      nxt_st.cause[`PMW_RCA_DBG_BIT] = nxt_st.cause[`PMW_RCA_DBG_BIT] | dbg_reset_req; // [RQ14] [RQ16]
    end
    nxt_st.rst_out = (nxt_st.seq_cnt != 16'h0);
  end

  // State register; power-on reset clears the cause record
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= ST_RST; // [RQ14] [RQ16]
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule

// ==== pmw_ctrl_assertions.sv ====
// Port-level checks on the power mode controller
`timescale 1ns/1ns
module pmw_ctrl_assertions #(
  parameter int RST_SEQ_CYC = 16
) (
  // Clock, reset and bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  // Event sources
  input wire logic crystal_oscillator_fast_ready,
  input wire logic adc_done,
  input wire logic rng_ready,
  input wire logic wdt_reset_req,
  input wire logic dbg_reset_req,
  // Controls
  input wire logic [2:0] power_mode,
  input wire logic power_down,
  input wire logic cpu_clk_stop,
  input wire logic wakeup_timer_stop,
  input wire logic wdt_hold_reset,
  input wire logic sys_reset,
  input wire logic miscellaneous_interrupt
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Mode decode and event timing
  a_misc_or: assert property (1'b1 |=> miscellaneous_interrupt ==
    $past(crystal_oscillator_fast_ready | adc_done | rng_ready)) else $error("misc irq wrong");
  a_standby_clk: assert property (cpu_clk_stop == (power_mode == 3'h7)) else $error("clk stop wrong");
  a_timer_stop: assert property (wakeup_timer_stop == (power_mode inside {3'h1, 3'h2}))
    else $error("timer stop wrong");
  a_down_mode: assert property (power_down == !(power_mode inside {3'h0, 3'h7}))
    else $error("power down wrong");
  a_no_reserved: assert property (!(power_mode inside {3'h5, 3'h6})) else $error("reserved mode");
  a_deep_wdt: assert property (power_mode == 3'h1 |-> wdt_hold_reset) else $error("wdt not held");
  a_rst_start: assert property ((wdt_reset_req || dbg_reset_req) |=> sys_reset [*8])
    else $error("reset too short");
  a_rst_end: assert property ($fell(sys_reset) |-> !$past(wdt_reset_req) && !$past(dbg_reset_req))
    else $error("reset ended early");
  a_read_wait: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
endmodule

bind pmw_ctrl pmw_ctrl_assertions #(.RST_SEQ_CYC(RST_SEQ_CYC)) u_chk (.hclk, .hresetn, .hsel, .htrans,
  .hwrite, .hready, .hreadyout, .crystal_oscillator_fast_ready, .adc_done, .rng_ready, .wdt_reset_req,
  .dbg_reset_req, .power_mode, .power_down, .cpu_clk_stop, .wakeup_timer_stop, .wdt_hold_reset,
  .sys_reset, .miscellaneous_interrupt);

// ==== pmw_ctrl_bench.sv ====
// Self-checking bench for the power mode controller
`timescale 1ns/1ns
`include "pmw_map.svh"
module pmw_ctrl_bench;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hung;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic wake_pin, wake_comp, wake_tick, radio_interrupt, pin_wakeup_interrupt;
  logic crystal_oscillator_fast_ready, adc_done, rng_ready, reset_pin_n, wdt_reset_req, dbg_reset_req;
  logic [7:0] interrupt_enable_reg_one;
  logic [2:0] power_mode;
  logic retention_latch_lock, wdt_hold_reset, sys_reset;
  int n_mismatch = 0;
  int checked = 0;

  // Design and processor model
  pmw_ctrl dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp(), .hrdata, .wake_pin, .wake_comp, .wake_tick,
    .radio_interrupt, .pin_wakeup_interrupt, .interrupt_enable_reg_one, .crystal_oscillator_fast_ready,
    .adc_done, .rng_ready, .reset_pin_n, .wdt_reset_req, .dbg_reset_req, .power_mode, .power_down(),
    .cpu_clk_stop(), .wakeup_timer_stop(), .retention_latch_lock, .wdt_hold_reset, .sys_reset,
    .miscellaneous_interrupt());
  pmw_cpu_model cpu (.hclk, .hreadyout, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hung);

  // Compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Register access
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    cpu.xfer(1'b0, idx, 32'h0, d);
    chk(d, exp);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] v);
    logic [31:0] d;
    cpu.xfer(1'b1, idx, v, d);
  endtask
  // Bounded wait for active and out of reset
  task automatic settle();
    int i;
    for (i = 0; i < 60; i++) begin
      if (power_mode === 3'h0 && sys_reset === 1'b0) break;
      @(posedge hclk);
    end
    if (i == 60) begin
      n_mismatch++;
      results();
    end
  endtask
  // Reset request: bit 2 pin, bit 1 watchdog, bit 0 debugger
  task automatic pulse(input logic [2:0] k);
    {reset_pin_n, wdt_reset_req, dbg_reset_req} <= {~k[2], k[1], k[0]};
    repeat (4) @(posedge hclk);
    {reset_pin_n, wdt_reset_req, dbg_reset_req} <= 3'h4;
    settle();
  endtask

  // Scenarios
  task automatic t_reset();
    rd(`PMW_IDX_PDC, 32'h0);
    rd(`PMW_IDX_WUS, 32'h0);
    rd(`PMW_IDX_OPM, 32'h0);
    rd(`PMW_IDX_RCA, 32'h0);
    rd(8'hA6, 32'h0);
  endtask
  task automatic t_modes();
    logic [31:0] f;
    for (int c = 1; c < 8; c++) begin
      wr(`PMW_IDX_PDC, 32'(c));
      repeat (3) @(posedge hclk);
      chk({29'h0, power_mode}, (c == 5 || c == 6) ? 32'h0 : 32'(c));
      if (c != 5 && c != 6) begin
        wake_pin <= (c == 1 || c == 4);
        wake_comp <= (c == 2);
        wake_tick <= (c == 3);
        radio_interrupt <= (c == 7);
        settle();
        {wake_pin, wake_comp, wake_tick, radio_interrupt} <= 4'h0;
        f = (c == 2) ? 32'h20 : (c == 3) ? 32'h40 : (c == 7) ? 32'h0 : 32'h80;
        rd(`PMW_IDX_PDC, f | 32'(c));
        rd(`PMW_IDX_PDC, 32'(c));
      end
    end
  endtask
  task automatic t_opts();
    wr(`PMW_IDX_OPM, 32'h3);
    rd(`PMW_IDX_OPM, 32'h3);
    wr(`PMW_IDX_PDC, 32'h4);
    repeat (3) @(posedge hclk);
    chk({30'h0, retention_latch_lock, wdt_hold_reset}, 32'h3);
    wake_pin <= 1'b1;
    settle();
    wake_pin <= 1'b0;
    wr(`PMW_IDX_OPM, 32'h0); // Settings restored before unlock
    wr(`PMW_IDX_PDC, 32'h3);
    repeat (3) @(posedge hclk);
    chk({30'h0, retention_latch_lock, wdt_hold_reset}, 32'h0);
    wake_tick <= 1'b1;
    settle();
    wake_tick <= 1'b0;
  endtask
  task automatic t_standby();
    wr(`PMW_IDX_WUS, 32'hC2);
    wr(`PMW_IDX_PDC, 32'h7);
    radio_interrupt <= 1'b1;
    repeat (8) @(posedge hclk);
    chk({29'h0, power_mode}, 32'h7);
    radio_interrupt <= 1'b0;
    {crystal_oscillator_fast_ready, adc_done, rng_ready} <= 3'h7;
    settle();
    {crystal_oscillator_fast_ready, adc_done, rng_ready} <= 3'h0;
    rd(`PMW_IDX_WUS, 32'hC2);
    wr(`PMW_IDX_WUS, 32'h08);
    wr(`PMW_IDX_PDC, 32'h7);
    repeat (3) @(posedge hclk);
    pin_wakeup_interrupt <= 1'b1;
    settle();
    pin_wakeup_interrupt <= 1'b0;
    rd(`PMW_IDX_PDC, 32'h87);
    wr(`PMW_IDX_WUS, 32'h20);
    wr(`PMW_IDX_PDC, 32'h7);
    repeat (3) @(posedge hclk);
    wake_tick <= 1'b1;
    settle();
    wake_tick <= 1'b0;
    rd(`PMW_IDX_PDC, 32'h47);
  endtask
  task automatic t_cause();
    pulse(3'h1);
    pulse(3'h2);
    rd(`PMW_IDX_RCA, 32'h6);
    wr(`PMW_IDX_RCA, 32'hFF);
    rd(`PMW_IDX_RCA, 32'h0);
    pulse(3'h4);
    rd(`PMW_IDX_RCA, 32'h1);
    rd(`PMW_IDX_WUS, 32'h0);
  endtask

  // Clock
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // Main sequence
  initial begin
    hresetn = 1'b0;
    {wake_pin, wake_comp, wake_tick, radio_interrupt, pin_wakeup_interrupt} = '0;
    {crystal_oscillator_fast_ready, adc_done, rng_ready, wdt_reset_req, dbg_reset_req} = '0;
    reset_pin_n = 1'b1;
    interrupt_enable_reg_one = 8'h02;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    settle();
    t_reset();
    t_modes();
    t_opts();
    t_standby();
    t_cause();
    results();
  end
  // Bus hang cut short
  always @(posedge hung) begin
    n_mismatch++;
    results();
  end
endmodule

// ==== pmw_map.svh ====
// Register map, field positions, reset values and counts for the power mode control block
// Operation
// (RQ1) Nonzero mode field write enters power saving
// (RQ2) 010/011 memory retention, timer off/on
// (RQ3) 001 deep sleep, 100 register, 111 standby
// (RQ4) Mode field reads previous mode, 000 power-off
// (RQ5) Bit 7 flags wakeup by pin
// (RQ6) Bit 6 flags wakeup by timer tick
// (RQ7) Bit 5 flags wakeup by comparator
// (RQ8) Flags clear on read or mode entry
// (RQ9) Options bit 1 locks retention latches
// (RQ10) Software restores settings before unlocking latches
// (RQ11) Options bit 0 resets watchdog in retention
// (RQ12) Software writes zeros to options bits 7:2
// (RQ13) All four sources start same reset sequence
// (RQ14) Cause bits: 001 pin, 010 watchdog, 100 debugger
// (RQ15) Any write clears the reset cause
// (RQ16) Reset causes accumulate until cleared
// (RQ17) Wakeup selections govern standby wake events
// (RQ18) Bits 7:6 select radio interrupt wake
// (RQ19) Bits 5:4 select timer tick wake
// (RQ20) Bits 3:2 select pin interrupt wake
// (RQ21) Bits 1:0 select miscellaneous interrupt wake
// (RQ22) Miscellaneous interrupt from oscillator, converter, random
// (RQ23) Reserved codes 101/110 start no transition
`ifndef PMW_MAP_SVH
`define PMW_MAP_SVH

// Register indices; byte address is four times the index
`define PMW_IDX_PDC 8'hA4
`define PMW_IDX_WUS 8'hA5
`define PMW_IDX_OPM 8'hAE
`define PMW_IDX_RCA 8'hB1

// Power down control fields
`define PMW_PDC_PIN_BIT 7
`define PMW_PDC_TICK_BIT 6
`define PMW_PDC_COMP_BIT 5

// Operating mode options fields
`define PMW_OPM_LATCH_BIT 1
`define PMW_OPM_WDT_BIT 0

// Wakeup select field positions (low bit of each pair)
`define PMW_WUS_RADIO_LSB 6
`define PMW_WUS_TICK_LSB 4
`define PMW_WUS_PIN_LSB 2
`define PMW_WUS_MISC_LSB 0

// Wakeup select codes
`define PMW_WSEL_IF_EN 2'h0
`define PMW_WSEL_ALWAYS 2'h2

// Reset cause bits
`define PMW_RCA_PIN_BIT 0
`define PMW_RCA_WDT_BIT 1
`define PMW_RCA_DBG_BIT 2

// Reset values
`define PMW_PDC_RST 8'h00
`define PMW_WUS_RST 8'h00
`define PMW_OPM_RST 8'h00

// Reset sequence length in clock cycles
`define PMW_RST_SEQ_CYC 16

`endif

// ==== pmw_pkg.sv ====
// Types shared by the power mode control block
package pmw_pkg;

  // Power saving mode codes
  typedef enum logic [2:0] {
    PMW_MODE_NONE = 3'h0,
    PMW_MODE_DEEP = 3'h1,
    PMW_MODE_MEM_TOFF = 3'h2,
    PMW_MODE_MEM_TON = 3'h3,
    PMW_MODE_REG_RET = 3'h4,
    PMW_MODE_RSV5 = 3'h5,
    PMW_MODE_RSV6 = 3'h6,
    PMW_MODE_STANDBY = 3'h7
  } pmw_mode_e;

  // Power sequencer states, Gray coded from active to down to wake; wake back to active flips both bits
  typedef enum logic [1:0] {
    PMW_ST_ACTIVE = 2'h0,
    PMW_ST_DOWN = 2'h1,
    PMW_ST_WAKE = 2'h3
  } pmw_fsm_e;

  // Whole state of the controller
  typedef struct packed {
    pmw_fsm_e fsm;
    logic [2:0] cur_mode;
    logic [2:0] prev_mode;
    logic [2:0] wake_flags;
    logic [1:0] opm;
    logic [7:0] wus;
    logic [2:0] cause;
    logic [15:0] seq_cnt;
    logic rst_out;
    logic misc_irq;
    logic [1:0] pin_s;
    logic [1:0] comp_s;
    logic [1:0] rstp_s;
    logic dp_wr;
    logic dp_rd;
    logic rd_done;
    logic [7:0] dp_idx;
    logic [31:0] rdata;
  } pmw_state_s;

endpackage
